// ==== rtl/dynamic_termination_control.sv ====
/*
  Dynamic on-die termination control: selects off, nominal or write
  strength for the data pins. Assumes pin and command inputs are
  synchronous to clk and that the controller keeps its own timing.
*/
`timescale 1ns/1ps
`default_nettype none
module dynamic_termination_control
  import dyn_term_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic odt_pin,
  input wire logic write_cmd,
  input wire logic write_chop,
  input wire logic [15:0] mode_reg_one,
  input wire logic [15:0] mode_reg_two,
  input wire logic [3:0] cas_write_latency,
  input wire logic [3:0] additive_latency,
  output logic term_on,
  output logic [3:0] term_divider,
  output logic write_sel,
  output logic term_unknown,
  output logic dynamic_active,
  output logic config_error
);
  logic [2:0] nominal_code;
  logic [1:0] write_code;
  logic dyn_enable;
  logic [LAT_W-1:0] odt_latency;
  logic [LAT_W-1:0] next_latency;
  logic [LAT_W-1:0] tap;
  logic [1:0] write_tap;
  logic pin_tap;
  logic write_event;
  logic [HOLD_W-1:0] hold;
  logic [HOLD_W-1:0] next_hold;
  logic next_wsel;
  logic [3:0] nom_div;
  logic [3:0] wr_div;
  logic [3:0] next_div;
  logic nom_reserved;
  logic wr_reserved;
  logic [1:0] skew_cnt;
  logic [1:0] next_skew;

  // Mode fields
  assign nominal_code = {mode_reg_one[NOM_BIT_HI], mode_reg_one[NOM_BIT_MID],
                         mode_reg_one[NOM_BIT_LO]};
  assign write_code = {mode_reg_two[WR_BIT_HI], mode_reg_two[WR_BIT_LO]};
  assign dyn_enable = mode_reg_two[WR_BIT_HI] | mode_reg_two[WR_BIT_LO];

  // Synchronous latency, also the nominal-to-write delay
  assign next_latency = ({1'b0, cas_write_latency} + {1'b0, additive_latency})
                        - ODT_BIAS_TCK;
  assign tap = odt_latency - TAP_ADVANCE;

  always_ff @(posedge clk) begin
    if (reset) begin
      odt_latency <= LAT_RESET;
    end else begin
      odt_latency <= next_latency;
    end
  end

  delay_line #(.WIDTH(1)) pin_delay (
    .clk(clk),
    .reset(reset),
    .din(odt_pin),
    .tap(tap),
    .dout(pin_tap)
  );

  // Each write travels with its own chop flag
  delay_line #(.WIDTH(2)) write_delay (
    .clk(clk),
    .reset(reset),
    .din({write_cmd, write_chop}),
    .tap(tap),
    .dout(write_tap)
  );

  assign write_event = write_tap[1] && dyn_enable;

  // Write-strength hold counter, reloaded by every delayed write while dynamic mode is on
  always_comb begin
    next_hold = hold;
    if (!dyn_enable) begin
      next_hold = '0;
    end else if (write_event) begin
      next_hold = write_tap[0] ? CHOP_TCK : FULL_TCK;
    end else if (hold != '0) begin
      next_hold = hold - 3'h1;
    end
  end

  assign next_wsel = next_hold != '0;

  // Strength decoding
  always_comb begin
    nom_reserved = 1'b0;
    case (nominal_code)
      NOM_OFF: nom_div = DIV_NONE;
      NOM_DIV4: nom_div = DIV_4;
      NOM_DIV2: nom_div = DIV_2;
      NOM_DIV6: nom_div = DIV_6;
      NOM_DIV12: nom_div = DIV_12;
      NOM_DIV8: nom_div = DIV_8;
      default: begin
        nom_div = DIV_NONE;
        nom_reserved = 1'b1;
      end
    endcase
  end

  always_comb begin
    wr_reserved = 1'b0;
    case (write_code)
      WR_DIV4: wr_div = DIV_4;
      WR_DIV2: wr_div = DIV_2;
      WR_OFF: wr_div = DIV_NONE;
      default: begin
        wr_div = DIV_NONE;
        wr_reserved = 1'b1;
      end
    endcase
  end

  // Pin gates on and off; writes only change the strength
  always_comb begin
    if (!pin_tap) begin
      next_div = DIV_NONE;
    end else if (next_wsel) begin
      next_div = wr_div;
    end else begin
      next_div = nom_div;
    end
  end

  // Skew window after the switch to write strength
  always_comb begin
    if (next_wsel && !write_sel) begin
      next_skew = SKEW_CYCLES;
    end else if (skew_cnt != 2'h0) begin
      next_skew = skew_cnt - 2'h1;
    end else begin
      next_skew = skew_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hold <= '0;
      write_sel <= 1'b0;
    end else begin
      hold <= next_hold;
      write_sel <= next_wsel;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      term_on <= 1'b0;
      term_divider <= DIV_NONE;
    end else begin
      term_on <= pin_tap;
      term_divider <= next_div;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      skew_cnt <= 2'h0;
      term_unknown <= 1'b0;
    end else begin
      skew_cnt <= next_skew;
      term_unknown <= next_skew != 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dynamic_active <= 1'b0;
      config_error <= 1'b0;
    end else begin
      dynamic_active <= dyn_enable;
      config_error <= nom_reserved || wr_reserved;
    end
  end

  // Helper counters for the checks below
  logic [SINCE_W-1:0] since_write;
  logic [SINCE_W-1:0] since_pin;
  logic last_chop;
  logic prev_pin;
  logic [SINCE_W-1:0] lat_wide;

  assign lat_wide = {1'b0, odt_latency};

  always_ff @(posedge clk) begin
    if (reset) begin
      since_write <= SINCE_MAX;
      since_pin <= SINCE_MAX;
      last_chop <= 1'b0;
      prev_pin <= 1'b0;
    end else begin
      prev_pin <= odt_pin;
      if (write_cmd) begin
        since_write <= 6'h01;
        last_chop <= write_chop;
      end else if (since_write != SINCE_MAX) begin
        since_write <= since_write + 6'h01;
      end
      if (odt_pin && !prev_pin) begin
        since_pin <= 6'h01;
      end else if (since_pin != SINCE_MAX) begin
        since_pin <= since_pin + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence write_strength_entry;
    $rose(write_sel) && since_write >= lat_wide;
  endsequence

  sequence write_strength_exit;
    $fell(write_sel) && dynamic_active && since_write >= lat_wide;
  endsequence

  a_nominal_to_write: assert property (
    write_strength_entry |-> since_write == lat_wide)
    else $error("write strength not reached at write latency minus two");

  a_write_to_nominal: assert property (
    write_strength_exit |-> since_write ==
      lat_wide + {3'h0, (last_chop ? CHOP_TCK : FULL_TCK)})
    else $error("return to nominal at wrong cycle");

  a_pin_on_latency: assert property (
    $rose(term_on) && since_pin >= lat_wide |-> since_pin == lat_wide)
    else $error("termination turn-on latency wrong");

  a_skew_window: assert property (
    $rose(write_sel) |-> term_unknown ##1 !term_unknown)
    else $error("skew window not one cycle at switch");

  a_nominal_codes: assert property (
    term_on && !write_sel && nominal_code == NOM_DIV12 |->
      term_divider == DIV_12)
    else $error("nominal code decode wrong");

  a_write_codes: assert property (
    term_on && write_sel && write_code == WR_DIV2 |-> term_divider == DIV_2)
    else $error("write code decode wrong");

  a_dynamic_enable: assert property (
    !dynamic_active [*2] |-> !write_sel)
    else $error("write strength while dynamic mode off");

  a_idle_nominal: assert property (
    !write_sel && $past(nominal_code) == nominal_code |->
      (term_divider == (term_on ? nom_div : DIV_NONE)))
    else $error("idle termination not nominal or off");
endmodule
`default_nettype wire

// ==== rtl/dyn_term_pkg.sv ====
/*
  Constants, mode-field layouts and latency figures for the dynamic
  termination control. Assumes all figures are in command clock cycles.
*/
// How it works
// - With dynamic mode on, a write switches to write strength after WL-2.
// - Write strength returns to nominal 4 or 6 clocks plus turn-off latency.
// - The pin still gates termination on and off through the latencies.
// - A skew window follows the nominal-to-write switch; value is unknown.
// - Nominal field is mode_reg_one bits 9,6,2; codes 110 and 111 reserved.
// - Write field is mode_reg_two bits 10,9; 00 off, 01 /4, 10 /2.
// - Dynamic switching is active when either bit 9 or bit 10 is set.
// - With no writes only nominal strength applies, gated by the pin.
// - Turn-off latency equals CAS write latency plus additive minus two.
`default_nettype none
package dyn_term_pkg;
  localparam int NOM_BIT_HI = 9;
  localparam int NOM_BIT_MID = 6;
  localparam int NOM_BIT_LO = 2;
  localparam int WR_BIT_HI = 10;
  localparam int WR_BIT_LO = 9;
  localparam logic [2:0] NOM_OFF = 3'h0;
  localparam logic [2:0] NOM_DIV4 = 3'h1;
  localparam logic [2:0] NOM_DIV2 = 3'h2;
  localparam logic [2:0] NOM_DIV6 = 3'h3;
  localparam logic [2:0] NOM_DIV12 = 3'h4;
  localparam logic [2:0] NOM_DIV8 = 3'h5;
  localparam logic [1:0] WR_OFF = 2'h0;
  localparam logic [1:0] WR_DIV4 = 2'h1;
  localparam logic [1:0] WR_DIV2 = 2'h2;
  localparam logic [3:0] DIV_NONE = 4'h0;
  localparam logic [3:0] DIV_2 = 4'h2;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_6 = 4'h6;
  localparam logic [3:0] DIV_8 = 4'h8;
  localparam logic [3:0] DIV_12 = 4'hc;
  localparam int LAT_W = 5;
  localparam int DELAY_DEPTH = 32;
  localparam logic [LAT_W-1:0] ODT_BIAS_TCK = 5'h02;
  localparam logic [LAT_W-1:0] TAP_ADVANCE = 5'h02;
  localparam logic [LAT_W-1:0] LAT_RESET = 5'h03;
  localparam int HOLD_W = 3;
  localparam logic [HOLD_W-1:0] CHOP_TCK = 3'h4;
  localparam logic [HOLD_W-1:0] FULL_TCK = 3'h6;
  localparam int SKEW_NOM_TENTHS = 5;
  localparam int SKEW_TOL_TENTHS = 2;
  localparam int SKEW_RAW = (SKEW_NOM_TENTHS + SKEW_TOL_TENTHS) / 10;
  localparam logic [1:0] SKEW_CYCLES = (SKEW_RAW > 0) ? 2'(SKEW_RAW) : 2'h1;
  localparam int SINCE_W = 6;
  localparam logic [SINCE_W-1:0] SINCE_MAX = 6'h3f;
endpackage
`default_nettype wire

// ==== rtl/delay_line.sv ====
/*
  Shift register with a run-time tap, used to delay the pin and write
  events by the programmed latency. Assumes tap below DELAY_DEPTH.
*/
`timescale 1ns/1ps
`default_nettype none
module delay_line
  import dyn_term_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  input wire logic [LAT_W-1:0] tap,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage [DELAY_DEPTH];

  // Stage k shows the input k+1 cycles later
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DELAY_DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= din;
      for (int i = 1; i < DELAY_DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign dout = stage[tap];
endmodule
`default_nettype wire

// ==== bench/controller_model.sv ====
/*
  Memory-controller model: drives the termination pin and write pulses.
  Assumes start is a one-cycle request synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module controller_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic chop,
  input wire logic no_write,
  input wire logic [1:0] extra,
  output logic odt_pin,
  output logic write_cmd,
  output logic write_chop
);
  logic [3:0] left;
  // Pin held high 4 or 6 clocks from the write, longer when slow
  always_ff @(posedge clk) begin
    if (reset) begin
      odt_pin <= 1'b0;
      left <= 4'h0;
    end else if (start) begin
      odt_pin <= 1'b1;
      left <= (chop ? 4'h3 : 4'h5) + {2'h0, extra};
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end else begin
      odt_pin <= 1'b0;
    end
  end
  // Chop flag toggles outside writes, where it carries no meaning
  always_ff @(posedge clk) begin
    if (reset) begin
      write_cmd <= 1'b0;
      write_chop <= 1'b0;
    end else begin
      write_cmd <= start & ~no_write;
      write_chop <= start ? chop : ~write_chop;
    end
  end
endmodule
`default_nettype wire

// ==== bench/dynamic_termination_control_test.sv ====
/*
  Self-checking bench for the dynamic termination control.
  Assumes the controller model drives the pin and write pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module dynamic_termination_control_test;
  import dyn_term_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic chop = 1'b0;
  logic no_write = 1'b0;
  logic chk = 1'b0;
  logic [1:0] extra = 2'h0;
  logic [15:0] mode_reg_one = 16'h0000;
  logic [15:0] mode_reg_two = 16'h0000;
  logic [3:0] cwl = 4'h5;
  logic [3:0] al = 4'h0;
  logic [2:0] nom = 3'h0;
  logic [1:0] wr = 2'h0;
  logic [31:0] seed = 32'h0000dd7e;
  logic odt_pin, write_cmd, write_chop, term_on, write_sel, sel, psel, on;
  logic term_unknown, dynamic_active, config_error;
  logic [3:0] term_divider;
  logic pin_h [4096];
  logic wr_h [4096];
  logic chop_h [4096];
  int cyc = 0;
  int lat = 3;
  int errors = 0;
  int compares = 0;

  initial begin
    forever #2.5 clk = ~clk;
  end

  controller_model u_ctrl (.clk(clk), .reset(reset), .start(start),
    .chop(chop), .no_write(no_write), .extra(extra), .odt_pin(odt_pin),
    .write_cmd(write_cmd), .write_chop(write_chop));

  dynamic_termination_control u_dut (.clk(clk), .reset(reset),
    .odt_pin(odt_pin), .write_cmd(write_cmd), .write_chop(write_chop),
    .mode_reg_one(mode_reg_one), .mode_reg_two(mode_reg_two),
    .cas_write_latency(cwl), .additive_latency(al), .term_on(term_on),
    .term_divider(term_divider), .write_sel(write_sel),
    .term_unknown(term_unknown), .dynamic_active(dynamic_active),
    .config_error(config_error));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [3:0] ndiv(input logic [2:0] c);
    case (c)
      3'h1: return DIV_4;
      3'h2: return DIV_2;
      3'h3: return DIV_6;
      3'h4: return DIV_12;
      3'h5: return DIV_8;
      default: return DIV_NONE;
    endcase
  endfunction

  // Latest write within reach sets the hold, by its own chop flag
  function automatic logic sel_at(input int n);
    int b;
    b = n - lat;
    if (wr == 2'h0 || pin_h[b & 4095] !== 1'b1) return 1'b0;
    for (int j = 0; j < 6; j++) begin
      if (wr_h[(b - j) & 4095]) return j < (chop_h[(b - j) & 4095] ? 4 : 6);
    end
    return 1'b0;
  endfunction

  task automatic check(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    pin_h[cyc & 4095] <= odt_pin;
    wr_h[cyc & 4095] <= write_cmd;
    chop_h[cyc & 4095] <= write_chop;
    if (cyc >= 20000) begin
      errors++;
      give_verdict();
    end
  end

  always @(negedge clk) begin
    if (chk) begin
      sel = sel_at(cyc);
      psel = sel_at(cyc - 1);
      on = pin_h[(cyc - lat) & 4095];
      check("term_on", {3'h0, on}, {3'h0, term_on});
      check("write_sel", {3'h0, sel}, {3'h0, write_sel});
      check("term_unknown", {3'h0, sel & ~psel},
            {3'h0, term_unknown});
      check("term_divider", sel ? (wr == 2'h1 ? DIV_4 : DIV_2) :
            (on ? ndiv(nom) : DIV_NONE), term_divider);
      check("dynamic_active", {3'h0, |wr}, {3'h0, dynamic_active});
      check("config_error", {3'h0, nom > 3'h5 || wr == 2'h3},
            {3'h0, config_error});
    end
  end

  // Settings change only while idle, with checks paused while they settle
  task automatic cfg(input logic [2:0] n, input logic [1:0] w,
                     input logic [3:0] c, input logic [3:0] a);
    repeat (48) @(posedge clk);
    chk <= 1'b0;
    seed = xs(seed);
    nom = n;
    wr = w;
    mode_reg_one <= {seed[15:10], n[2], seed[8:7], n[1], seed[5:3], n[0],
                     seed[1:0]};
    mode_reg_two <= {seed[31:27], w, seed[24:16]};
    cwl <= c;
    al <= a;
    lat = c + a - 2;
    repeat (40) @(posedge clk);
    chk <= 1'b1;
  endtask

  task automatic traffic(input int n, input logic nw);
    no_write <= nw;
    repeat (n) begin
      seed = xs(seed);
      start <= 1'b1;
      chop <= seed[0];
      extra <= seed[2:1];
      @(posedge clk);
      repeat (seed[5:3]) begin
        start <= 1'b0;
        @(posedge clk);
      end
    end
    start <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    cfg(3'h2, 2'h1, 4'h5, 4'h0);
    traffic(30, 1'b0);
    cfg(3'h3, 2'h2, 4'hc, 4'h3);
    traffic(30, 1'b0);
    cfg(3'h1, 2'h0, 4'h6, 4'h1);
    traffic(20, 1'b0);
    for (int i = 4; i < 8; i++) begin
      cfg(3'(i), 2'(i), 4'h7, 4'h2);
      traffic(10, 1'b1);
    end
    repeat (12) begin
      seed = xs(seed);
      cfg(3'(seed[7:0] % 8'd3 + 8'd1), 2'(seed[15:8] % 8'd3),
          {1'b0, seed[18:16]} + 4'h5, {2'h0, seed[20:19]});
      traffic(20, 1'b0);
    end
    repeat (48) @(posedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
